// ### serial_pkg.sv
package serial_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_TXH = 3'h2;
  localparam logic [2:0] ADDR_TXSTA = 3'h3;
  localparam logic [2:0] ADDR_RXH = 3'h4;
  localparam logic [2:0] ADDR_RXSTA = 3'h5;
  localparam int CMD_XTAL = 7;
  localparam int CMD_RXEN_B = 6;
  localparam int CMD_RCSEL_LSB = 3;
  localparam int CMD_PAR_EVEN = 2;
  localparam int CMD_PAR_EN = 1;
  localparam int CMD_WL8 = 0;
  localparam int CTRL_ECHO = 7;
  localparam int CTRL_RXEN_A = 6;
  localparam int CTRL_TXEN = 5;
  localparam int CTRL_RXINV = 4;
  localparam int CTRL_TXINV = 3;
  localparam int CTRL_BR_LSB = 0;
  localparam logic [7:0] CMD_RST = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Baud timing: source ticks per half bit
  // ----------------------------------------------------------------
  localparam logic [6:0] HALF_BASE_RC = 7'h08;
  localparam logic [6:0] HALF_BASE_XTAL = 7'h07;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP = 3'b100
  } ser_state_t;

  // Parity bit for a 7 or 8 bit word; odd parity inverts the xor.
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic wl8,
                                     input logic even);
    logic p;
    p = ^(wl8 ? d : {1'b0, d[6:0]});
    return even ? p : ~p;
  endfunction

endpackage

// ### baud_if.sv
`timescale 1ns/1ps
interface baud_if;
  logic src_tick;
  logic xtal_sel;
  logic [2:0] rc_sel;
  logic [2:0] br;
  logic restart;
  logic half_tick;
  modport gen(input src_tick, xtal_sel, rc_sel, br, restart,
              output half_tick);
  modport user(output restart, input half_tick);
endinterface

// ### baud_gen.sv
`timescale 1ns/1ps
module baud_gen (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Configuration, source tick and half-bit tick.
  baud_if.gen bif
);
  import serial_pkg::*;

  logic [6:0] pre_r;
  logic [6:0] div_r;
  logic half_r;
  logic [7:0] pre_lim;
  logic [6:0] div_n;
  logic pre_done;

  // ----------------------------------------------------------------
  // Divider selection
  // ----------------------------------------------------------------
  // The crystal path divides by 14 per bit, so 2400 comes out 2.48
  // percent slow; no integer ratio gets closer.
  always_comb begin
    pre_lim = (8'h01 << bif.rc_sel) - 8'h01;
    div_n = (bif.xtal_sel ? HALF_BASE_XTAL : HALF_BASE_RC)
            << (2'd3 - bif.br[1:0]);
    pre_done = bif.src_tick
               && (bif.xtal_sel || {1'b0, pre_r} == pre_lim);
  end

  // Restart holds the counters at zero so a frame starts in phase.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || bif.restart) begin
      pre_r <= 7'h00;
      div_r <= 7'h00;
      half_r <= 1'b0;
    end else begin
      half_r <= 1'b0;
      if (pre_done) begin
        pre_r <= 7'h00;
        if (div_r == div_n - 7'h01) begin
          div_r <= 7'h00;
          half_r <= 1'b1;
        end else begin
          div_r <= div_r + 7'h01;
        end
      end else if (bif.src_tick) begin
        pre_r <= pre_r + 7'h01;
      end
    end
  end

  assign bif.half_tick = half_r;

endmodule

// ### serial_rx.sv
`timescale 1ns/1ps
module serial_rx (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Synchronised line and frame format.
  input wire logic i_line,
  input wire logic i_enable,
  input wire logic i_wl8,
  input wire logic i_par_en,
  input wire logic i_par_even,
  baud_if.user bif,
  // Received word and its flags.
  output logic o_done,
  output logic [7:0] o_word,
  output logic o_start_err,
  output logic o_par_err,
  output logic o_frame_err,
  output logic o_active
);
  import serial_pkg::*;

  ser_state_t st_r;
  logic ph_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic serr_r;
  logic perr_r;
  logic mid;

  // Half ticks alternate bit edge and bit middle after the start.
  assign mid = bif.half_tick && (ph_r || st_r == SER_START);
  assign bif.restart = (st_r == SER_IDLE);
  assign o_active = (st_r != SER_IDLE);

  // Frame walk; a drop of both enables abandons the word.
  always_ff @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    if (i_sys_rst || !i_enable) begin
      st_r <= SER_IDLE;
      ph_r <= 1'b0;
      cnt_r <= 3'h0;
      serr_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      if (bif.half_tick) ph_r <= ~ph_r & (st_r != SER_START);
      unique case (st_r)
        SER_IDLE: if (!i_line) st_r <= SER_START;
        SER_START: if (mid) begin
          serr_r <= i_line;
          perr_r <= 1'b0;
          cnt_r <= 3'h0;
          st_r <= SER_DATA;
        end
        SER_DATA: if (mid) begin
          sh_r <= {i_line, sh_r[7:1]};
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == (i_wl8 ? 3'h7 : 3'h6))
            st_r <= i_par_en ? SER_PARITY : SER_STOP;
        end
        SER_PARITY: if (mid) begin
          perr_r <= i_line != parity_of(i_wl8 ? sh_r : sh_r >> 1,
                                        i_wl8, i_par_even);
          st_r <= SER_STOP;
        end
        SER_STOP: if (mid) begin
          o_word <= i_wl8 ? sh_r : {1'b0, sh_r[7:1]};
          o_start_err <= serr_r;
          o_par_err <= perr_r;
          o_frame_err <= !i_line;
          o_done <= 1'b1;
          st_r <= SER_IDLE;
        end
      endcase
    end
  end

  property p_rx_off;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_enable |=> !o_active && !o_done;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("Receiver stayed active while disabled.");

endmodule

// ### async_serial_transceiver.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module async_serial_transceiver (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Register port.
  input wire logic [serial_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // Baud clock sources.
  input wire logic i_rc_osc_clk,
  input wire logic i_xtal_osc_clk,
  // Serial pads.
  input wire logic i_port_b_line7,
  output logic o_port_b_line6,
  // Event outputs.
  output logic o_irq_rx_full,
  output logic o_irq_tx_empty
);
  import serial_pkg::*;

  // ----------------------------------------------------------------
  // Pad and clock synchronisers
  // ----------------------------------------------------------------
  // Index 0 receive pad, 1 RC clock, 2 crystal clock.
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [1:0] clk_d_r;
  logic src_tick;
  logic rx_line;

  // Two flops per input, and a third on each clock for edge detect; the first stage is read only by the second.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      meta_r <= 3'h1;
      sync_r <= 3'h1;
      clk_d_r <= 2'h0;
    end else begin
      meta_r <= {i_xtal_osc_clk, i_rc_osc_clk, i_port_b_line7};
      sync_r <= meta_r;
      clk_d_r <= sync_r[2:1];
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] cmd_r;
  logic [7:0] ctrl_r;
  logic [7:0] txh_r;
  logic tx_full_r;
  logic [7:0] rxh_r;
  logic rx_full_r;
  logic ovr_r;
  logic serr_r;
  logic perr_r;
  logic ferr_r;
  logic [7:0] rd_data_r;
  logic wr_cmd;
  logic wr_ctrl;
  logic wr_txh;
  logic wr_rxsta;
  logic rd_rxh;
  logic wl8;
  logic par_en;
  logic par_even;
  logic tx_inv;
  logic echo;

  assign wr_cmd = i_wr_en && i_addr == ADDR_CMD;
  assign wr_ctrl = i_wr_en && i_addr == ADDR_CTRL;
  assign wr_txh = i_wr_en && i_addr == ADDR_TXH;
  assign wr_rxsta = i_wr_en && i_addr == ADDR_RXSTA;
  assign rd_rxh = i_rd_en && i_addr == ADDR_RXH;
  assign wl8 = cmd_r[CMD_WL8];
  assign par_en = cmd_r[CMD_PAR_EN];
  assign par_even = cmd_r[CMD_PAR_EVEN];
  assign tx_inv = ctrl_r[CTRL_TXINV];
  assign echo = ctrl_r[CTRL_ECHO];

  // Selected source edge drives both baud generators.
  assign src_tick = cmd_r[CMD_XTAL]
                    ? (sync_r[2] && !clk_d_r[1])
                    : (sync_r[1] && !clk_d_r[0]);
  assign rx_line = sync_r[0] ^ ctrl_r[CTRL_RXINV];

  // Configuration registers.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cmd_r <= CMD_RST;
      ctrl_r <= CTRL_RST;
    end else begin
      if (wr_cmd) cmd_r <= i_wr_data;
      if (wr_ctrl) ctrl_r <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Baud generators, one per direction
  // ----------------------------------------------------------------
  // Separate generators let each direction keep its own bit phase.
  baud_if bif_tx();
  baud_if bif_rx();

  assign bif_tx.src_tick = src_tick;
  assign bif_tx.xtal_sel = cmd_r[CMD_XTAL];
  assign bif_tx.rc_sel = cmd_r[CMD_RCSEL_LSB +: 3];
  assign bif_tx.br = ctrl_r[CTRL_BR_LSB +: 3];
  assign bif_rx.src_tick = src_tick;
  assign bif_rx.xtal_sel = cmd_r[CMD_XTAL];
  assign bif_rx.rc_sel = cmd_r[CMD_RCSEL_LSB +: 3];
  assign bif_rx.br = ctrl_r[CTRL_BR_LSB +: 3];

  baud_gen u_baud_tx (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .bif(bif_tx.gen)
  );

  baud_gen u_baud_rx (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .bif(bif_rx.gen)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ser_state_t tx_st_r;
  logic tx_ph_r;
  logic [2:0] tx_cnt_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_line_r;
  logic tx_pin_r;
  logic irq_tx_r;
  logic tx_load;
  logic tx_end;

  assign tx_load = ctrl_r[CTRL_TXEN] && tx_full_r
                   && tx_st_r == SER_IDLE;
  assign tx_end = bif_tx.half_tick && tx_ph_r;
  assign bif_tx.restart = (tx_st_r == SER_IDLE);

  // Holding flag; a write in the load cycle keeps it set.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      txh_r <= DATA_RST;
      tx_full_r <= 1'b0;
    end else begin
      if (wr_txh) txh_r <= i_wr_data;
      tx_full_r <= wr_txh
                   || (tx_full_r && !tx_load);
    end
  end

  // Shift register walk: start, data, optional parity, stop.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_st_r <= SER_IDLE;
      tx_ph_r <= 1'b0;
      tx_cnt_r <= 3'h0;
      tx_sh_r <= DATA_RST;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (tx_load) begin
      tx_sh_r <= txh_r;
      tx_par_r <= parity_of(txh_r, wl8, par_even);
      tx_line_r <= 1'b0;
      tx_ph_r <= 1'b0;
      tx_st_r <= SER_START;
    end else begin
      if (bif_tx.half_tick) tx_ph_r <= ~tx_ph_r;
      if (tx_end) begin
        unique case (tx_st_r)
          SER_IDLE: tx_line_r <= 1'b1;
          SER_START: begin
            tx_line_r <= tx_sh_r[0];
            tx_cnt_r <= 3'h0;
            tx_st_r <= SER_DATA;
          end
          SER_DATA: begin
            tx_sh_r <= tx_sh_r >> 1;
            tx_cnt_r <= tx_cnt_r + 3'h1;
            if (tx_cnt_r == (wl8 ? 3'h7 : 3'h6)) begin
              tx_line_r <= par_en ? tx_par_r : 1'b1;
              tx_st_r <= par_en ? SER_PARITY : SER_STOP;
            end else begin
              tx_line_r <= tx_sh_r[1];
            end
          end
          SER_PARITY: begin
            tx_line_r <= 1'b1;
            tx_st_r <= SER_STOP;
          end
          SER_STOP: begin
            tx_line_r <= 1'b1;
            tx_st_r <= SER_IDLE;
          end
        endcase
      end
    end
  end

  // Pad flop; echo bypasses the shifter, so own data is not sent.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_pin_r <= 1'b1;
      irq_tx_r <= 1'b0;
    end else begin
      tx_pin_r <= (echo ? sync_r[0] : tx_line_r)
                  ^ tx_inv;
      irq_tx_r <= tx_load;
    end
  end

  // ----------------------------------------------------------------
  // Receiver and its holding register
  // ----------------------------------------------------------------
  logic rx_done;
  logic [7:0] rx_word;
  logic rx_serr;
  logic rx_perr;
  logic rx_ferr;
  logic rx_active;
  logic irq_rx_r;

  serial_rx u_rx (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_line(rx_line),
    .i_enable(ctrl_r[CTRL_RXEN_A] || cmd_r[CMD_RXEN_B]),
    .i_wl8(wl8),
    .i_par_en(par_en),
    .i_par_even(par_even),
    .bif(bif_rx.user),
    .o_done(rx_done),
    .o_word(rx_word),
    .o_start_err(rx_serr),
    .o_par_err(rx_perr),
    .o_frame_err(rx_ferr),
    .o_active(rx_active)
  );

  // A word landing in the read or clear cycle wins over the clear.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rxh_r <= DATA_RST;
      rx_full_r <= 1'b0;
      ovr_r <= 1'b0;
      serr_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      irq_rx_r <= 1'b0;
    end else begin
      irq_rx_r <= rx_done;
      rx_full_r <= rx_done || (rx_full_r && !rd_rxh);
      ovr_r <= (rx_done && rx_full_r && !rd_rxh)
               || (ovr_r && !wr_rxsta);
      if (rx_done) begin
        rxh_r <= rx_word;
        serr_r <= rx_serr;
        perr_r <= rx_perr;
        ferr_r <= rx_ferr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the strobe; else zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_rd_en) begin
      rd_data_r <= 8'h00;
    end else begin
      unique case (i_addr)
        ADDR_CMD: rd_data_r <= cmd_r;
        ADDR_CTRL: rd_data_r <= ctrl_r;
        ADDR_TXH: rd_data_r <= txh_r;
        ADDR_TXSTA: rd_data_r <= {6'h00, tx_st_r != SER_IDLE,
                                  tx_full_r};
        ADDR_RXH: rd_data_r <= rxh_r;
        ADDR_RXSTA: rd_data_r <= {2'h0, serr_r, perr_r, ferr_r,
                                  ovr_r, rx_active, rx_full_r};
        default: rd_data_r <= 8'h00;
      endcase
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_port_b_line6 = tx_pin_r;
  assign o_irq_tx_empty = irq_tx_r;
  assign o_irq_rx_full = irq_rx_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tx_full_set;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_txh |=> tx_full_r;
  endproperty
  a_tx_full_set: assert property (p_tx_full_set)
    else $error("Holding write did not set full.");

  property p_tx_load;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    tx_load && !wr_txh |=> !tx_full_r && tx_st_r == SER_START
                           ##1 o_port_b_line6 == tx_inv;
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("Load did not start a frame.");

  property p_tx_irq;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    $fell(tx_full_r) |-> o_irq_tx_empty;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("Empty event missing on full fall.");

  property p_idle_high;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    tx_st_r == SER_IDLE && !echo ##1 !echo
      |-> tx_pin_r == !$past(tx_inv);
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("Transmit line not idle high.");

  property p_echo;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    echo |=> tx_pin_r == ($past(sync_r[0]) ^ $past(tx_inv));
  endproperty
  a_echo: assert property (p_echo)
    else $error("Echo did not follow the receive line.");

  property p_rx_done;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rx_done |=> rx_full_r && o_irq_rx_full && rxh_r == $past(rx_word);
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("Received word not transferred.");

  property p_rx_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rd_rxh && !rx_done |=> !rx_full_r;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("Holding read did not clear full.");

  property p_ovr_clr;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_rxsta && !rx_done |=> !ovr_r;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("Status write did not clear overrun.");

  property p_ovr_set;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    rx_done && rx_full_r && !rd_rxh |=> ovr_r;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("Overrun not flagged.");

endmodule

// ### serial_partner.sv
`timescale 1ns/1ps
module serial_partner (
  // Line from and to the block.
  input wire logic i_pad,
  output logic o_pad
);
  int bit_ns = 2560;
  logic inv = 1'b0;

  // The remote end drives its line and idles it high.
  initial o_pad = 1'b1;

  // Frame bits leave lowest first: start, data, parity, stop.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      o_pad = f[i] ^ inv;
      #(bit_ns);
    end
    o_pad = ~inv;
  endtask

  // Samples mid-bit; it returns at mid stop so a next frame is not missed.
  task automatic recv(input int n, output logic [11:0] f);
    f = 12'h000;
    wait ((i_pad ^ inv) === 1'b1);
    wait ((i_pad ^ inv) === 1'b0);
    #(bit_ns / 2);
    for (int i = 0; i < n; i++) begin
      f[i] = i_pad ^ inv;
      if (i < n - 1) #(bit_ns);
    end
  endtask
endmodule

// ### async_serial_transceiver_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); \
  end \
end
module async_serial_transceiver_tb;
  import serial_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] o_rd_data;
  logic i_rc_osc_clk = 1'b0;
  logic i_xtal_osc_clk = 1'b0;
  logic line7;
  logic o_port_b_line6;
  logic o_irq_rx_full;
  logic o_irq_tx_empty;
  int miscompares = 0;
  int n_checks = 0;
  int n_rx_irq = 0;
  int n_tx_irq = 0;
  logic [11:0] g1;
  logic [11:0] g2;

  // ----------------------------------------------------------------
  // Block, remote end and clocks
  // ----------------------------------------------------------------
  async_serial_transceiver uut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_rc_osc_clk(i_rc_osc_clk),
    .i_xtal_osc_clk(i_xtal_osc_clk),
    .i_port_b_line7(line7), .o_port_b_line6(o_port_b_line6),
    .o_irq_rx_full(o_irq_rx_full), .o_irq_tx_empty(o_irq_tx_empty)
  );
  serial_partner partner (.i_pad(o_port_b_line6), .o_pad(line7));

  // Baud sources run well below the system clock so edges are seen.
  initial forever #20 i_clk_sys = ~i_clk_sys;
  initial forever #80 i_rc_osc_clk = ~i_rc_osc_clk;
  initial forever #73 i_xtal_osc_clk = ~i_xtal_osc_clk;

  // Event pulses are counted so scenarios can check how many came.
  always @(posedge i_clk_sys) begin
    if (o_irq_rx_full === 1'b1) n_rx_irq++;
    if (o_irq_tx_empty === 1'b1) n_tx_irq++;
  end

  // ----------------------------------------------------------------
  // Register bus and frame helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic ck(input logic [2:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(o_rd_data, e)
    @(posedge i_clk_sys);
  endtask

  // Expected line image of one frame, lowest bit first.
  function automatic logic [11:0] frm(input logic [7:0] d,
      input logic w8, input logic pe, input logic ev);
    logic [7:0] m;
    m = w8 ? d : {1'b0, d[6:0]};
    frm = {3'b000, m, 1'b0};
    frm[8 + w8] = pe ? ((^m) ^ ~ev) : 1'b1;
    frm[9 + w8] = pe;
  endfunction

  task automatic tx_frame(input logic [7:0] d, input int n);
    fork
      partner.recv(n, g1);
      wr(ADDR_TXH, d);
    join
    repeat (40) @(posedge i_clk_sys);
  endtask

  task automatic rx_frame(input logic [11:0] f, input int n);
    partner.send(f, n);
    repeat (8) @(posedge i_clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int a = 0; a < 8; a++) begin
      ck(a[2:0], a == 0 ? CMD_RST : a == 1 ? CTRL_RST : 8'h00);
    end
    wr(ADDR_TXSTA, 8'hFF);
    wr(3'h6, 8'hFF);
    ck(ADDR_TXSTA, 8'h00);
    ck(3'h6, 8'h00);
  endtask

  task automatic t_tx;
    wr(ADDR_CTRL, 8'h27);
    fork
      begin
        partner.recv(10, g1);
        partner.recv(10, g2);
      end
      begin
        wr(ADDR_TXH, 8'hA5);
        repeat (40) @(posedge i_clk_sys);
        wr(ADDR_TXH, 8'h3C);
        ck(ADDR_TXSTA, 8'h03);
      end
    join
    repeat (80) @(posedge i_clk_sys);
    `CHK(g1, frm(8'hA5, 1'b1, 1'b0, 1'b0))
    `CHK(g2, frm(8'h3C, 1'b1, 1'b0, 1'b0))
    ck(ADDR_TXSTA, 8'h00);
    `CHK(n_tx_irq, 2)
  endtask

  task automatic t_fmt;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(ADDR_CMD, {5'b00000, c});
      tx_frame(8'hC9, 9 + c[0] + c[1]);
      `CHK(g1, frm(8'hC9, c[0], c[1], c[2]))
    end
  endtask

  task automatic t_rx;
    wr(ADDR_CMD, 8'h03);
    wr(ADDR_CTRL, 8'h47);
    rx_frame(frm(8'h5A, 1'b1, 1'b1, 1'b0), 11);
    ck(ADDR_RXSTA, 8'h01);
    ck(ADDR_RXH, 8'h5A);
    ck(ADDR_RXSTA, 8'h00);
    rx_frame(frm(8'h11, 1'b1, 1'b1, 1'b0), 11);
    // The third word carries a wrong parity bit and overruns the unread second.
    rx_frame(frm(8'h22, 1'b1, 1'b1, 1'b0) ^ 12'h200, 11);
    ck(ADDR_RXSTA, 8'h15);
    wr(ADDR_RXSTA, 8'h00);
    ck(ADDR_RXSTA, 8'h11);
    ck(ADDR_RXH, 8'h22);
    rx_frame(frm(8'h33, 1'b1, 1'b1, 1'b0) ^ 12'h400, 11);
    // A low stop bit looks like a new start; drop reception to abandon it.
    wr(ADDR_CTRL, 8'h07);
    ck(ADDR_RXSTA, 8'h09);
    ck(ADDR_RXH, 8'h33);
    wr(ADDR_CTRL, 8'h07);
    wr(ADDR_CMD, 8'h43);
    rx_frame(frm(8'h44, 1'b1, 1'b1, 1'b0), 11);
    ck(ADDR_RXH, 8'h44);
    wr(ADDR_CMD, 8'h03);
    rx_frame(frm(8'h55, 1'b1, 1'b1, 1'b0), 11);
    ck(ADDR_RXSTA, 8'h00);
    `CHK(n_rx_irq, 5)
  endtask

  task automatic t_inv;
    // Receive stays off while the pad polarity flips, so no false start.
    wr(ADDR_CTRL, 8'h3F);
    partner.inv = 1'b1;
    partner.o_pad = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    wr(ADDR_CTRL, 8'h7F);
    rx_frame(frm(8'h6B, 1'b1, 1'b1, 1'b0), 11);
    ck(ADDR_RXH, 8'h6B);
    tx_frame(8'h96, 11);
    `CHK(g1, frm(8'h96, 1'b1, 1'b1, 1'b0))
    wr(ADDR_CTRL, 8'h9F);
    partner.o_pad = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    `CHK(o_port_b_line6, 1'b0)
    partner.o_pad = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    `CHK(o_port_b_line6, 1'b1)
    partner.o_pad = 1'b1;
    partner.inv = 1'b0;
  endtask

  // Every baud code of both sources; the fastest crystal bit is 14 source edges.
  task automatic t_rate;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CMD, {k[2], 7'h01});
      wr(ADDR_CTRL, {5'b00100, ~k[2:0]});
      partner.bit_ns = (k[2] ? 14 * 146 : 16 * 160) << k[1:0];
      tx_frame(8'h4D, 10);
      `CHK(g1, frm(8'h4D, 1'b1, 1'b0, 1'b0))
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after a 20 cycle reset.
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    t_reset;
    t_tx;
    t_fmt;
    t_rx;
    t_inv;
    t_rate;
    end_of_test;
  end

  // The scenarios need about 1.2 ms; a hang is cut off well beyond that.
  initial begin
    #3000000;
    miscompares++;
    end_of_test;
  end
endmodule
